// ===== core/pcs_regs.vh
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// register indices; byte address is four times the index
`define PCS_IDX_PCL        8'h06
`define PCS_IDX_SCC        8'h20
`define PCS_IDX_STAT       8'h21

// system clock control fields
`define PCS_SCC_RATE_BIT   0
`define PCS_SCC_RST        8'h01

// status fields
`define PCS_STAT_PC_LSB    0
`define PCS_STAT_PH_LSB    12
`define PCS_STAT_DUMMY_BIT 16

// program counter width, reset value and vectors
`define PCS_PC_W           12
`define PCS_PC_RST         12'h000
`define PCS_VEC_USB        12'h004
`define PCS_VEC_TMR        12'h00C

// clock rates and derived divider counts
`define PCS_CLK_HZ         125000000
`define PCS_SYS_HZ_FAST    12000000
`define PCS_SYS_HZ_SLOW    6000000
`define PCS_DIV_FAST       (`PCS_CLK_HZ / `PCS_SYS_HZ_FAST)
`define PCS_DIV_SLOW       (`PCS_CLK_HZ / `PCS_SYS_HZ_SLOW)
`define PCS_PHASES         4

// decoder operation codes
`define PCS_OP_NONE        3'h0
`define PCS_OP_JUMP        3'h1
`define PCS_OP_CALL        3'h2
`define PCS_OP_RET         3'h3
`define PCS_OP_RETI        3'h4
`define PCS_OP_SKIP        3'h5

// bus responses
`define PCS_RESP_OKAY      2'h0
`define PCS_RESP_SLVERR    2'h2

`endif

// ===== core/pcs_phase_gen.v
`timescale 1ns/1ps
`include "pcs_regs.vh"

module pcs_phase_gen (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       rate_fast,
   output reg  [3:0] phase_ff,
   output reg  [1:0] phase_idx_ff,
   output reg        cyc_end_ff
);

   // counts are worked out at full width, then cut to the counter width on purpose
   localparam integer DIV_FAST_N = `PCS_DIV_FAST;
   localparam integer DIV_SLOW_N = `PCS_DIV_SLOW;
   localparam integer LAST_PH_N  = `PCS_PHASES - 1;
   localparam [4:0]   DIV_FAST   = DIV_FAST_N[4:0];
   localparam [4:0]   DIV_SLOW   = DIV_SLOW_N[4:0];
   localparam [1:0]   LAST_PH    = LAST_PH_N[1:0];

   reg  [4:0] div_cnt_ff;
   wire [4:0] div_top;
   wire       sys_tick;

   // divider limit follows the rate select; the period rounds down
   assign div_top  = rate_fast ? DIV_FAST - 5'h01 : DIV_SLOW - 5'h01;
   assign sys_tick = (div_cnt_ff >= div_top);

   // system clock tick, then four non-overlapping phases per cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_ff   <= 5'h00;
         phase_idx_ff <= 2'h0;
         phase_ff     <= 4'h1;
         cyc_end_ff   <= 1'b0;
      end else begin
         div_cnt_ff <= sys_tick ? 5'h00 : div_cnt_ff + 5'h01;
         cyc_end_ff <= sys_tick && (phase_idx_ff == LAST_PH);
         if (sys_tick) begin
            phase_idx_ff <= phase_idx_ff + 2'h1;
            phase_ff     <= {phase_ff[2:0], phase_ff[3]};
         end
      end
   end

endmodule

// ===== core/pcs_sequencer.v
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcs_regs.vh"

module pcs_sequencer (
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [9:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [9:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // decoder side, same clock, held for the whole execute cycle
   input  wire [2:0]  exec_op,
   input  wire        skip_cond,
   input  wire [11:0] jump_target,
   input  wire [11:0] stack_top,
   // interrupt controller side
   input  wire        usb_int_req,
   input  wire        tmr_int_req,
   input  wire        stack_full,
   // program memory and stack side
   output reg  [11:0] fetch_addr_ff,
   output reg         fetch_stb_ff,
   output reg  [11:0] exec_addr_ff,
   output reg         exec_valid_ff,
   output reg  [11:0] push_addr_ff,
   output reg         push_stb_ff,
   output reg         pop_stb_ff,
   output reg         usb_ack_ff,
   output reg         tmr_ack_ff,
   output wire [3:0]  phase_ff
);

   localparam [7:0] IDX_PCL  = `PCS_IDX_PCL;
   localparam [7:0] IDX_SCC  = `PCS_IDX_SCC;
   localparam [7:0] IDX_STAT = `PCS_IDX_STAT;

   reg  [11:0] pc_ff;
   reg  [11:0] nxt_pc;
   reg         dummy_ff;
   reg  [7:0]  scc_ff;
   reg  [7:0]  pcl_val_ff;
   reg         pcl_pend_ff;
   reg         aw_hold_ff;
   reg  [7:0]  aw_idx_ff;
   reg         w_hold_ff;
   reg  [31:0] w_data_ff;
   reg  [3:0]  w_strb_ff;
   reg         nxt_dummy;
   reg         nxt_push;
   reg         nxt_pop;
   reg         nxt_usb_ack;
   reg         nxt_tmr_ack;
   reg  [11:0] nxt_push_addr;

   wire [1:0]  phase_idx;
   wire        cyc_end;
   wire        do_write;
   wire        wr_hit;
   wire        op_live;
   wire        irq_ok;

   // byte address to register index; low two bits are ignored
   function [7:0] addr_idx;
      input [9:0] addr;
      begin
         addr_idx = addr[9:2];
      end
   endfunction

   // one step through the program space, wrapping past the top word
   function [11:0] pc_step;
      input [11:0] pc;
      begin
         pc_step = pc + 12'h001;
      end
   endfunction

   function mapped;
      input [7:0] idx;
      begin
         mapped = (idx == IDX_PCL) || (idx == IDX_SCC) || (idx == IDX_STAT);
      end
   endfunction

   pcs_phase_gen u_phase (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .rate_fast    (scc_ff[`PCS_SCC_RATE_BIT]),
      .phase_ff     (phase_ff),
      .phase_idx_ff (phase_idx),
      .cyc_end_ff   (cyc_end)
   );

   // write completes once both address and data are held
   assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
   assign wr_hit   = mapped(aw_idx_ff);
   // a dummy cycle executes nothing, so its op is not honoured
   assign op_live  = !dummy_ff && (exec_op != `PCS_OP_NONE);
   assign irq_ok   = !stack_full && !dummy_ff && !op_live && !pcl_pend_ff;

   // write address and data channels, taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff    <= 1'b0;
         w_hold_ff     <= 1'b0;
         aw_idx_ff     <= 8'h00;
         w_data_ff     <= 32'h00000000;
         w_strb_ff     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PCS_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            aw_idx_ff  <= addr_idx(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_ff   <= 1'b0;
            w_hold_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // software registers; a low-byte write waits for the cycle boundary
   always @(posedge aclk) begin
      if (!aresetn) begin
         scc_ff      <= `PCS_SCC_RST;
         pcl_val_ff  <= 8'h00;
         pcl_pend_ff <= 1'b0;
      end else begin
         if (do_write && (aw_idx_ff == IDX_SCC) && w_strb_ff[0])
            scc_ff <= w_data_ff[7:0];
         if (do_write && (aw_idx_ff == IDX_PCL) && w_strb_ff[0]) begin
            pcl_val_ff  <= w_data_ff[7:0];
            pcl_pend_ff <= 1'b1;
         // held over a boundary taken by a live op, so the short jump is not lost
         end else if (cyc_end && !op_live) begin
            pcl_pend_ff <= 1'b0;
         end
      end
   end

   // read channel: one-cycle accept, data registered the next cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PCS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(addr_idx(s_axi_araddr)) ? `PCS_RESP_OKAY
                                                          : `PCS_RESP_SLVERR;
            case (addr_idx(s_axi_araddr))
               IDX_PCL:  s_axi_rdata <= {24'h000000, pc_ff[7:0]};
               IDX_SCC:  s_axi_rdata <= {24'h000000, scc_ff};
               IDX_STAT: s_axi_rdata <= {15'h0000, dummy_ff, 2'h0, phase_idx,
                                         pc_ff};
               default:  s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // next counter at the cycle boundary; transfers outrank the low-byte
   // write, which outranks interrupts, so no accepted event is dropped
   always @* begin
      nxt_pc        = pc_step(pc_ff);
      nxt_dummy     = 1'b0;
      nxt_push      = 1'b0;
      nxt_pop       = 1'b0;
      nxt_usb_ack   = 1'b0;
      nxt_tmr_ack   = 1'b0;
      nxt_push_addr = pc_ff;
      if (op_live) begin
         case (exec_op)
            `PCS_OP_JUMP: begin
               nxt_pc    = jump_target;
               nxt_dummy = 1'b1;
            end
            `PCS_OP_CALL: begin
               nxt_pc    = jump_target;
               nxt_dummy = 1'b1;
               nxt_push  = 1'b1;
            end
            `PCS_OP_RET, `PCS_OP_RETI: begin
               nxt_pc    = stack_top;
               nxt_dummy = 1'b1;
               nxt_pop   = 1'b1;
            end
            `PCS_OP_SKIP: begin
               // fetch already sits at skip+1, so stepping lands on skip+2
               nxt_dummy = skip_cond;
            end
            default: begin
               nxt_dummy = 1'b0;
            end
         endcase
      end else if (pcl_pend_ff) begin
         nxt_pc    = {pc_ff[11:8], pcl_val_ff};
         nxt_dummy = 1'b1;
      end else if (irq_ok && usb_int_req) begin
         nxt_pc      = `PCS_VEC_USB;
         nxt_dummy   = 1'b1;
         nxt_push    = 1'b1;
         nxt_usb_ack = 1'b1;
      end else if (irq_ok && tmr_int_req) begin
         nxt_pc      = `PCS_VEC_TMR;
         nxt_dummy   = 1'b1;
         nxt_push    = 1'b1;
         nxt_tmr_ack = 1'b1;
      end
   end

   // fetch/execute pipeline; the fetched word executes one cycle later
   always @(posedge aclk) begin
      if (!aresetn) begin
         pc_ff         <= `PCS_PC_RST;
         dummy_ff      <= 1'b1;
         fetch_addr_ff <= `PCS_PC_RST;
         fetch_stb_ff  <= 1'b0;
         exec_addr_ff  <= `PCS_PC_RST;
         exec_valid_ff <= 1'b0;
         push_addr_ff  <= `PCS_PC_RST;
         push_stb_ff   <= 1'b0;
         pop_stb_ff    <= 1'b0;
         usb_ack_ff    <= 1'b0;
         tmr_ack_ff    <= 1'b0;
      end else begin
         fetch_stb_ff <= cyc_end;
         push_stb_ff  <= cyc_end && nxt_push;
         pop_stb_ff   <= cyc_end && nxt_pop;
         usb_ack_ff   <= cyc_end && nxt_usb_ack;
         tmr_ack_ff   <= cyc_end && nxt_tmr_ack;
         if (cyc_end) begin
            exec_addr_ff  <= pc_ff;
            exec_valid_ff <= !nxt_dummy;
            dummy_ff      <= nxt_dummy;
            pc_ff         <= nxt_pc;
            fetch_addr_ff <= nxt_pc;
            push_addr_ff  <= nxt_push_addr;
         end
      end
   end

endmodule

// ===== sim/pcs_seq_checker.sv
`timescale 1ns/1ps

module pcs_seq_checker (
   input logic        aclk,
   input logic        aresetn,
   input logic        s_axi_arready,
   input logic [11:0] fetch_addr_ff,
   input logic        fetch_stb_ff,
   input logic [11:0] exec_addr_ff,
   input logic        exec_valid_ff,
   input logic        push_stb_ff,
   input logic        pop_stb_ff,
   input logic        usb_ack_ff,
   input logic        tmr_ack_ff,
   input logic [3:0]  phase_ff
);
   logic [7:0]  gap_ff;
   logic [11:0] last_ff;
   logic        seen_ff;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // edges since the last boundary; a rate switch mixes ticks of 10 and 20
   always @(posedge aclk) begin
      if (!aresetn) begin
         gap_ff  <= 8'h00;
         last_ff <= 12'h000;
         seen_ff <= 1'h0;
      end else if (fetch_stb_ff) begin
         gap_ff  <= 8'h01;
         last_ff <= fetch_addr_ff;
         seen_ff <= 1'h1;
      end else begin
         gap_ff <= gap_ff + 8'h01;
      end
   end

   phase_onehot_a: assert property ($onehot(phase_ff))
      else $error("phase not one-hot");
   cycle_len_a: assert property (fetch_stb_ff && seen_ff |->
      gap_ff inside {8'h28, 8'h32, 8'h3C, 8'h46, 8'h50})
      else $error("instruction cycle length wrong");
   pc_reset_a: assert property (disable iff (1'h0) !aresetn |=>
      fetch_addr_ff == 12'h000 && !exec_valid_ff) else $error("reset pc wrong");
   exec_stage_a: assert property (fetch_stb_ff && exec_valid_ff |->
      exec_addr_ff == last_ff) else $error("execute word mismatch");
   pc_incr_a: assert property (fetch_stb_ff && exec_valid_ff |->
      fetch_addr_ff == last_ff + 12'h001) else $error("pc not incremented");
   load_dummy_a: assert property (push_stb_ff || pop_stb_ff |->
      fetch_stb_ff && !exec_valid_ff) else $error("load without dummy");
   usb_vec_a: assert property (usb_ack_ff |->
      fetch_addr_ff == 12'h004 && push_stb_ff) else $error("usb vector wrong");
   tmr_vec_a: assert property (tmr_ack_ff |->
      fetch_addr_ff == 12'h00C && push_stb_ff) else $error("timer vector wrong");
   ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready held");

   cover property (usb_ack_ff);
   cover property (tmr_ack_ff);
   cover property (pop_stb_ff);
   cover property (fetch_stb_ff && seen_ff && gap_ff == 8'h50);
endmodule

bind pcs_sequencer pcs_seq_checker u_chk (.*);

// ===== sim/program_counter_sequencer_tb.sv
`timescale 1ns/1ps
`include "pcs_regs.vh"

module program_counter_sequencer_tb;
   logic        aclk = 1'h0;
   logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, skip_cond, usb_int_req, tmr_int_req, stack_full;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb, phase_ff;
   logic [2:0]  exec_op;
   logic [11:0] jump_target, stack_top, fetch_addr_ff, exec_addr_ff, push_addr_ff, t, v, s;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        fetch_stb_ff, exec_valid_ff, push_stb_ff, pop_stb_ff, usb_ack_ff, tmr_ack_ff, c;
   integer      mismatches = 0, num_checks = 0, cyc = 0, n, k;

   pcs_sequencer dut (.*);

   always #4 aclk = ~aclk;

   // hang guard, well above the expected run length
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t timeout", $time);
         stop_test;
      end
   end

   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // register index to byte address
   function automatic logic [9:0] badr(input logic [7:0] idx);
      return {idx, 2'h0};
   endfunction

   // aclk periods per instruction cycle at a given system rate
   function automatic integer cyc_len(input integer sys_hz);
      return `PCS_PHASES * (`PCS_CLK_HZ / sys_hz);
   endfunction

   // low-byte write target: page kept, low byte replaced
   function automatic logic [11:0] short_jump(input logic [11:0] pc, input logic [7:0] val);
      return {pc[11:8], val};
   endfunction

   // returns at the edge where a boundary strobe is seen
   task wait_stb;
      @(posedge aclk);
      while (fetch_stb_ff !== 1'h1) @(posedge aclk);
   endtask

   task meas(input integer e);
      wait_stb;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (fetch_stb_ff !== 1'h1);
      chk(k, e);
   endtask

   // ops on a dummy word are ignored, so wait for a real one
   task xfer(input logic [2:0] op, input logic [11:0] tg, input logic [11:0] e, input logic d);
      wait_stb;
      while (exec_valid_ff !== 1'h1) wait_stb;
      exec_op     <= op;
      jump_target <= tg;
      stack_top   <= tg;
      wait_stb;
      exec_op <= `PCS_OP_NONE;
      chk(fetch_addr_ff, e);
      chk(exec_valid_ff, !d);
   endtask

   task axi_wr(input logic [9:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      k = 0;
      while (k == 0) begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'h0;
            k = 1;
         end
      end
   endtask

   task axi_rd(input logic [9:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      k = 0;
      while (k == 0) begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'h0;
            k = 1;
         end
      end
   endtask

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
       skip_cond, usb_int_req, tmr_int_req, stack_full, s_axi_awaddr, s_axi_araddr,
       s_axi_wdata, exec_op, jump_target, stack_top} = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'h4E47));
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      // first cycle out of reset fetches word zero under a dummy execute
      @(posedge aclk);
      chk(fetch_addr_ff, 12'h000);
      chk(exec_valid_ff, 1'h0);
      chk(phase_ff, 4'h1);
      wait_stb;
      chk(fetch_addr_ff, 12'h001);
      chk(exec_addr_ff, 12'h000);
      chk(exec_valid_ff, 1'h1);
      axi_rd(badr(`PCS_IDX_SCC));
      chk(rd, {24'h000000, `PCS_SCC_RST});
      meas(cyc_len(`PCS_SYS_HZ_FAST));
      axi_wr(badr(`PCS_IDX_SCC), 32'h00000000);
      meas(cyc_len(`PCS_SYS_HZ_SLOW));
      axi_wr(badr(`PCS_IDX_SCC), 32'h00000001);
      meas(cyc_len(`PCS_SYS_HZ_FAST));
      for (n = 0; n < 4; n++) begin
         t = {4'($urandom), 8'h10};
         v = 12'($urandom);
         s = 12'($urandom);
         c = 1'($urandom);
         xfer(`PCS_OP_JUMP, t, t, 1'h1);
         xfer(`PCS_OP_CALL, v, v, 1'h1);
         chk(push_addr_ff, t + 12'h001);
         xfer(n[0] ? `PCS_OP_RETI : `PCS_OP_RET, s, s, 1'h1);
         chk(pop_stb_ff, 1'h1);
         skip_cond <= c;
         xfer(`PCS_OP_SKIP, 12'h000, s + 12'h002, c);
         // a full stack holds the request off until room appears
         xfer(`PCS_OP_JUMP, t, t, 1'h1);
         stack_full  <= 1'h1;
         usb_int_req <= 1'h1;
         xfer(`PCS_OP_NONE, 12'h000, t + 12'h002, 1'h0);
         stack_full <= 1'h0;
         wait_stb;
         chk(fetch_addr_ff, 12'h004);
         chk(usb_ack_ff, 1'h1);
         usb_int_req <= 1'h0;
         tmr_int_req <= 1'h1;
         wait_stb;
         chk(fetch_addr_ff, 12'h005);
         wait_stb;
         chk(fetch_addr_ff, 12'h00C);
         chk(tmr_ack_ff, 1'h1);
         tmr_int_req <= 1'h0;
         xfer(`PCS_OP_JUMP, t, t, 1'h1);
         wait_stb;
         axi_wr(badr(`PCS_IDX_PCL), {24'h0, v[7:0]});
         chk(rs, `PCS_RESP_OKAY);
         wait_stb;
         chk(fetch_addr_ff, short_jump(t, v[7:0]));
         chk(exec_valid_ff, 1'h0);
         axi_rd(badr(`PCS_IDX_PCL));
         chk(rd, {24'h0, v[7:0]});
      end
      xfer(`PCS_OP_JUMP, 12'hFFF, 12'hFFF, 1'h1);
      // status during the dummy after the jump: top word, phase zero, dummy set
      axi_rd(badr(`PCS_IDX_STAT));
      chk(rd, (32'h00000001 << `PCS_STAT_DUMMY_BIT) | 32'h00000FFF);
      wait_stb;
      chk(fetch_addr_ff, 12'h000);
      axi_rd(badr(8'h10));
      chk(rs, `PCS_RESP_SLVERR);
      axi_wr(badr(8'h11), 32'h0000005A);
      chk(rs, `PCS_RESP_SLVERR);
      stop_test;
   end
endmodule
